//--- rtl/capsel_top.sv
// configurable auxiliary pin selector: six pins, each with one function
// assumes function codes come from configuration memory and hold after load
//
// How it works
// - tri-state leaves pad undriven; drive options hold constant 1 or 0.
// - power enable low once configured, high again while suspended.
// - sleep indicator low during suspend, high otherwise.
// - clock options give 25, 12.5 or 6.25 MHz; stopped in suspend.
// - GPIO only selectable on first four pins; others on all six.
// - charger detect drives high while attached to a dedicated charger.
// - inverted charger detect is open drain, pulling low on charger.
// - write-strobe option outputs the active-low bit-bang write strobe.
// - read-strobe option outputs the active-low bit-bang read strobe.
// - transmit-empty option outputs the active-low transmit buffer empty flag.
// - receive-full option outputs the active-low receive buffer full flag.
// - bus-power sense option reads the pin as bus power present.
// - timestamp option toggles the pin on every start-of-frame.
// - keep-awake input, active low, blocks suspend while unplugged.
// - exactly six pins, each with own selection and drive strength.
// - flags report the host-to-i2c receive and i2c-to-host transmit buffers.
module capsel_top
  import capsel_pkg::*;
#(
  parameter int unsigned NUM_PINS = CAPSEL_NUM_PINS,
  parameter int unsigned NUM_GPIO = CAPSEL_NUM_GPIO_PINS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic config_memory_valid,
  input wire logic [NUM_PINS*CAPSEL_SEL_W-1:0] config_memory_sel,
  input wire logic [NUM_PINS-1:0] config_memory_strength,
  input wire logic usb_configured,
  input wire logic usb_suspend,
  input wire logic charger_attached,
  input wire logic bitbang_write_strobe_n,
  input wire logic bitbang_read_strobe_n,
  input wire logic tx_buffer_empty,
  input wire logic rx_buffer_full,
  input wire logic sof_received,
  input wire logic [NUM_PINS-1:0] gpio_out,
  input wire logic [NUM_PINS-1:0] gpio_oe_n,
  output logic [NUM_PINS-1:0] gpio_in,
  input wire logic [NUM_PINS-1:0] aux_config_pin_in,
  output logic [NUM_PINS-1:0] aux_config_pin_out,
  output logic [NUM_PINS-1:0] aux_config_pin_oe_n,
  output logic [NUM_PINS-1:0] aux_config_pin_strength,
  output logic power_enable_n,
  output logic bus_power_sense,
  output logic bus_power_sense_valid,
  output logic keep_awake,
  output logic config_loaded
);
  logic loaded_q;
  logic [NUM_PINS*CAPSEL_SEL_W-1:0] sel_q;
  logic [NUM_PINS-1:0] strength_q;
  logic stamp_q;
  logic power_en_n_q;
  logic [NUM_PINS-1:0] out_q;
  logic [NUM_PINS-1:0] oe_n_q;
  logic [NUM_PINS-1:0] in_q;
  logic vbus_q;
  logic vbus_valid_q;
  logic awake_q;
  logic clk_fast;
  logic clk_mid;
  logic clk_slow;

  // selections captured once after reset and frozen
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      loaded_q <= 1'b0;
      sel_q <= '0;
      strength_q <= '0;
    end else if (config_memory_valid && !loaded_q) begin
      loaded_q <= 1'b1;
      sel_q <= config_memory_sel;
      strength_q <= config_memory_strength;
    end
  end

  // power enable: low once configured, high while suspended
  wire logic power_en_n_d = ~(usb_configured & ~usb_suspend);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      power_en_n_q <= 1'b1;
      stamp_q <= 1'b0;
    end else begin
      power_en_n_q <= power_en_n_d;
      if (sof_received) begin
        stamp_q <= ~stamp_q;
      end
    end
  end

  // pin clocks stop while suspended
  capsel_clk_div #(.HALF(CAPSEL_FAST_HALF)) u_div_fast (
    .clk(clk),
    .reset(reset),
    .stop(usb_suspend),
    .clk_out(clk_fast)
  );
  capsel_clk_div #(.HALF(CAPSEL_MID_HALF)) u_div_mid (
    .clk(clk),
    .reset(reset),
    .stop(usb_suspend),
    .clk_out(clk_mid)
  );
  capsel_clk_div #(.HALF(CAPSEL_SLOW_HALF)) u_div_slow (
    .clk(clk),
    .reset(reset),
    .stop(usb_suspend),
    .clk_out(clk_slow)
  );

  logic [NUM_PINS-1:0] out_d;
  logic [NUM_PINS-1:0] oe_n_d;
  logic [NUM_PINS-1:0] is_vbus;
  logic [NUM_PINS-1:0] is_awake;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      wire logic [CAPSEL_SEL_W-1:0] code = sel_q[gi*CAPSEL_SEL_W +: CAPSEL_SEL_W];
      wire logic gpio_ok = (gi < NUM_GPIO);
      logic o;
      logic oen;
      always_comb begin
        o = 1'b0;
        oen = 1'b1;
        if (loaded_q) begin
          case (code)
            CAPSEL_FN_TRISTATE: begin
              o = 1'b0;
              oen = 1'b1;
            end
            CAPSEL_FN_DRIVE1: begin
              o = 1'b1;
              oen = 1'b0;
            end
            CAPSEL_FN_DRIVE0: begin
              o = 1'b0;
              oen = 1'b0;
            end
            CAPSEL_FN_PWR_EN: begin
              o = power_en_n_q;
              oen = 1'b0;
            end
            CAPSEL_FN_SLEEP: begin
              o = ~usb_suspend;
              oen = 1'b0;
            end
            CAPSEL_FN_CLK_FAST: begin
              o = clk_fast;
              oen = 1'b0;
            end
            CAPSEL_FN_CLK_MID: begin
              o = clk_mid;
              oen = 1'b0;
            end
            CAPSEL_FN_CLK_SLOW: begin
              o = clk_slow;
              oen = 1'b0;
            end
            CAPSEL_FN_GPIO: begin
              // pins past the gpio range stay undriven
              o = gpio_ok ? gpio_out[gi] : 1'b0;
              oen = gpio_ok ? gpio_oe_n[gi] : 1'b1;
            end
            CAPSEL_FN_CHARGER: begin
              o = charger_attached;
              oen = 1'b0;
            end
            CAPSEL_FN_CHARGER_N: begin
              o = 1'b0;
              oen = ~charger_attached;
            end
            CAPSEL_FN_BB_WR: begin
              o = bitbang_write_strobe_n;
              oen = 1'b0;
            end
            CAPSEL_FN_BB_RD: begin
              o = bitbang_read_strobe_n;
              oen = 1'b0;
            end
            CAPSEL_FN_TX_EMPTY: begin
              o = ~tx_buffer_empty;
              oen = 1'b0;
            end
            CAPSEL_FN_RX_FULL: begin
              o = ~rx_buffer_full;
              oen = 1'b0;
            end
            CAPSEL_FN_TIMESTAMP: begin
              o = stamp_q;
              oen = 1'b0;
            end
            default: begin
              o = 1'b0;
              oen = 1'b1;
            end
          endcase
        end
      end
      assign out_d[gi] = o;
      assign oe_n_d[gi] = oen;
      assign is_vbus[gi] = loaded_q && (code == CAPSEL_FN_BUS_POWER);
      assign is_awake[gi] = loaded_q && (code == CAPSEL_FN_KEEP_AWAKE);
    end
  endgenerate

  // any pin chosen as bus-power sense reports high; keep-awake is active low
  wire logic vbus_d = |(is_vbus & aux_config_pin_in);
  wire logic awake_d = |(is_awake & ~aux_config_pin_in);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_q <= '0;
      oe_n_q <= '1;
      in_q <= '0;
      vbus_q <= 1'b0;
      vbus_valid_q <= 1'b0;
      awake_q <= 1'b0;
    end else begin
      out_q <= out_d;
      oe_n_q <= oe_n_d;
      in_q <= aux_config_pin_in;
      vbus_q <= vbus_d;
      vbus_valid_q <= |is_vbus;
      awake_q <= awake_d;
    end
  end

  assign aux_config_pin_out = out_q;
  assign aux_config_pin_oe_n = oe_n_q;
  assign aux_config_pin_strength = strength_q;
  assign gpio_in = in_q;
  assign power_enable_n = power_en_n_q;
  assign bus_power_sense = vbus_q;
  assign bus_power_sense_valid = vbus_valid_q;
  assign keep_awake = awake_q;
  assign config_loaded = loaded_q;
endmodule : capsel_top

//--- inc/capsel_pkg.sv
// package for the configurable auxiliary pin selector
// assumes a single 250 MHz clock and function codes loaded from configuration memory
package capsel_pkg;
  localparam int unsigned CAPSEL_NUM_PINS = 6;
  localparam int unsigned CAPSEL_NUM_GPIO_PINS = 4;
  localparam int unsigned CAPSEL_SEL_W = 5;
  // clock figures in kHz
  localparam int unsigned CAPSEL_SYS_CLK_KHZ = 250000;
  localparam int unsigned CAPSEL_FAST_KHZ = 24000;
  localparam int unsigned CAPSEL_MID_KHZ = 12000;
  localparam int unsigned CAPSEL_SLOW_KHZ = 6000;
  // half period in system cycles, rounded down, at least one
  localparam int unsigned CAPSEL_FAST_HALF = CAPSEL_SYS_CLK_KHZ / (2 * CAPSEL_FAST_KHZ);
  localparam int unsigned CAPSEL_MID_HALF = CAPSEL_SYS_CLK_KHZ / (2 * CAPSEL_MID_KHZ);
  localparam int unsigned CAPSEL_SLOW_HALF = CAPSEL_SYS_CLK_KHZ / (2 * CAPSEL_SLOW_KHZ);
  localparam int unsigned CAPSEL_DIV_W = 8;

  typedef enum logic [4:0] {
    CAPSEL_FN_TRISTATE = 5'h00,
    CAPSEL_FN_DRIVE1 = 5'h01,
    CAPSEL_FN_DRIVE0 = 5'h02,
    CAPSEL_FN_PWR_EN = 5'h03,
    CAPSEL_FN_SLEEP = 5'h04,
    CAPSEL_FN_CLK_FAST = 5'h05,
    CAPSEL_FN_CLK_MID = 5'h06,
    CAPSEL_FN_CLK_SLOW = 5'h07,
    CAPSEL_FN_GPIO = 5'h08,
    CAPSEL_FN_CHARGER = 5'h09,
    CAPSEL_FN_CHARGER_N = 5'h0a,
    CAPSEL_FN_BB_WR = 5'h0b,
    CAPSEL_FN_BB_RD = 5'h0c,
    CAPSEL_FN_TX_EMPTY = 5'h0d,
    CAPSEL_FN_RX_FULL = 5'h0e,
    CAPSEL_FN_BUS_POWER = 5'h0f,
    CAPSEL_FN_TIMESTAMP = 5'h10,
    CAPSEL_FN_KEEP_AWAKE = 5'h11
  } capsel_fn_t;

  localparam logic [CAPSEL_SEL_W-1:0] CAPSEL_SEL_RESET = 5'h00;
endpackage : capsel_pkg

//--- rtl/capsel_clk_div.sv
// square-wave divider producing one pin clock from the system clock
// assumes the single system clock; stop holds the output low
module capsel_clk_div
  import capsel_pkg::*;
#(
  parameter int unsigned HALF = 5
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic stop,
  output logic clk_out
);
  logic [CAPSEL_DIV_W-1:0] cnt_q;
  logic clk_q;
  wire logic wrap = (cnt_q == CAPSEL_DIV_W'(HALF - 1));

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
      clk_q <= 1'b0;
    end else if (stop) begin
      cnt_q <= '0;
      clk_q <= 1'b0;
    end else if (wrap) begin
      cnt_q <= '0;
      clk_q <= ~clk_q;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign clk_out = clk_q;
endmodule : capsel_clk_div

//--- tb/capsel_props.sv
// checker for the auxiliary pin selector, watching pin 0 and power enable
// assumes the top module's ports only; attached by the bind at the foot
module capsel_props
  import capsel_pkg::*;
#(
  parameter int unsigned NUM_PINS = CAPSEL_NUM_PINS,
  parameter int unsigned NUM_GPIO = CAPSEL_NUM_GPIO_PINS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic config_memory_valid,
  input wire logic [NUM_PINS*CAPSEL_SEL_W-1:0] config_memory_sel,
  input wire logic usb_configured,
  input wire logic usb_suspend,
  input wire logic charger_attached,
  input wire logic sof_received,
  input wire logic [NUM_PINS-1:0] aux_config_pin_out,
  input wire logic [NUM_PINS-1:0] aux_config_pin_oe_n,
  input wire logic power_enable_n,
  input wire logic config_loaded
);
  logic [4:0] c_q;
  logic got_q;
  logic ld_q;
  wire ok = config_loaded && ld_q;
  wire o0 = aux_config_pin_out[0];
  wire e0 = aux_config_pin_oe_n[0];
  // keep the code of pin 0 from the first valid load
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      c_q <= 5'h00;
      got_q <= 1'b0;
      ld_q <= 1'b0;
    end else begin
      ld_q <= config_loaded;
      if (config_memory_valid && !got_q) begin
        c_q <= config_memory_sel[4:0];
        got_q <= 1'b1;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_load_first: assert property (config_memory_valid && !got_q |=> config_loaded)
    else $error("selection not loaded");
  a_tri_release: assert property (ok && c_q inside {5'h00, 5'h0f, 5'h11} |-> e0)
    else $error("pad driven while released");
  a_drive_const: assert property (ok && c_q inside {5'h01, 5'h02} |-> !e0 && o0 == (c_q == 5'h01))
    else $error("constant drive wrong");
  a_sleep_level: assert property (ok && c_q == 5'h04 |=> !e0 && o0 == !$past(usb_suspend))
    else $error("sleep pin wrong");
  a_pwr_level: assert property ($stable({usb_configured, usb_suspend}) [*3]
    |-> power_enable_n == !(usb_configured && !usb_suspend)) else $error("power enable wrong");
  a_clk_stopped: assert property ((ok && c_q inside {5'h05, 5'h06, 5'h07} && usb_suspend) [*3]
    |-> !o0 && !e0) else $error("clock runs in suspend");
  a_clk_fast_half: assert property (ok && c_q == 5'h05 && $rose(o0)
    |-> (o0 [*5] ##1 !o0) or (##[0:5] usb_suspend)) else $error("fast clock half period wrong");
  a_stamp_toggle: assert property (ok && c_q == 5'h10
    |-> ##2 ((o0 != $past(o0)) == $past(sof_received, 2))) else $error("stamp toggle wrong");
  a_charger_od: assert property (ok && c_q == 5'h0a
    |=> e0 == !$past(charger_attached) && (e0 || !o0)) else $error("open drain charger wrong");
endmodule : capsel_props

bind capsel_top capsel_props #(.NUM_PINS(NUM_PINS), .NUM_GPIO(NUM_GPIO)) u_props (
  .clk, .reset, .config_memory_valid, .config_memory_sel, .usb_configured, .usb_suspend,
  .charger_attached, .sof_received, .aux_config_pin_out, .aux_config_pin_oe_n,
  .power_enable_n, .config_loaded);

//--- tb/capsel_board.sv
// board logic on the far side of the six auxiliary pads
// assumes per-pad data and an active-low drive enable from the device
module capsel_board #(
  parameter logic PULL_LEVEL = 1'b0
) (
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe_n,
  input wire logic [5:0] drv,
  input wire logic [5:0] lvl,
  output logic [5:0] pad
);
  timeunit 1ns;
  timeprecision 1ps;
  // released pads take the board level or the pull-down that a p-channel switch needs
  assign pad = (~pin_oe_n & pin_out) | (pin_oe_n & ((drv & lvl) | (~drv & {6{PULL_LEVEL}})));
endmodule : capsel_board

//--- tb/capsel_tb_top.sv
// self-checking bench for the auxiliary pin selector
// assumes the board model on the pads and the checker bound to the top
module capsel_tb_top
  import capsel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset = 1, vld = 0, cfgd = 0, susp = 0, chg = 0, wr = 1, rd = 1;
  logic txe = 0, rxf = 0, sof = 0, p = 0;
  logic [29:0] sel = '0;
  logic [5:0] st = '0, sv = '0, go = '0, goe = '1, lvl = '0;
  logic [7:0] r = 8'h60, x = '0;
  logic [4:0] cd = '0;
  wire [5:0] pin_in, pout, poe, pstr, gin;
  wire pwr_n, sense, sense_v, wake, loaded;
  logic [15:0] q[$];
  int error_cnt = 0, compares = 0;
  always #2 clk = ~clk;
  capsel_top dut (.clk(clk), .reset(reset), .config_memory_valid(vld), .config_memory_sel(sel),
    .config_memory_strength(sv), .usb_configured(cfgd), .usb_suspend(susp),
    .charger_attached(chg), .bitbang_write_strobe_n(wr), .bitbang_read_strobe_n(rd),
    .tx_buffer_empty(txe), .rx_buffer_full(rxf), .sof_received(sof), .gpio_out(go),
    .gpio_oe_n(goe), .gpio_in(gin), .aux_config_pin_in(pin_in), .aux_config_pin_out(pout),
    .aux_config_pin_oe_n(poe), .aux_config_pin_strength(pstr), .power_enable_n(pwr_n),
    .bus_power_sense(sense), .bus_power_sense_valid(sense_v), .keep_awake(wake),
    .config_loaded(loaded));
  capsel_board board (.pin_out(pout), .pin_oe_n(poe), .drv(6'h0f), .lvl(lvl), .pad(pin_in));
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task final_report;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  function automatic logic [7:0] lf(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lf
  // expected {sense valid, pad 1 in, pads 5..4 in, strength, power enable, keep awake, sense,
  // pin 4 oe_n, pin 0 oe_n, pin 0 data}; released pads 1..3 follow the board, 4..5 the pull
  function automatic logic [15:0] ex(input logic [4:0] c, input logic [7:0] v);
    logic d, o;
    d = 1'b1;
    o = 1'b0;
    case (c)
      5'h01: o = 1'b1;
      5'h03: o = !(v[1] && !v[0]);
      5'h04: o = !v[0];
      5'h08: begin
        d = !v[5];
        o = v[6];
      end
      5'h09: o = v[2];
      5'h0a: d = v[2];
      5'h0b: o = v[3];
      5'h0c: o = v[4];
      5'h0d: o = !v[5];
      5'h0e: o = !v[6];
      5'h10: o = p;
      5'h00, 5'h0f, 5'h11, 5'h1f: d = 1'b0;
      default: ;
    endcase
    return {c == 5'h0f, v[7], 2'b00, st, !(v[1] && !v[0]), c == 5'h11 && !v[7],
      c == 5'h0f && v[7], 1'b1, !d, d & o};
  endfunction : ex
  always @(negedge clk) begin
    while (q.size() > 0) chk("pins", {sense_v, gin[1], gin[5:4], pstr, pwr_n, wake, sense,
      poe[4], poe[0], pout[0] & ~poe[0]}, q.pop_front());
  end
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    final_report();
  end
  initial begin
    for (int k = 0; k < 19; k++) begin
      cd = (k == 18) ? 5'h1f : 5'(k);
      st = r[5:0];
      p = 1'b0;
      @(posedge clk);
      reset <= 1'b1;
      susp <= 1'b0;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      vld <= 1'b1;
      sel <= {5'h00, 5'h08, 15'h0000, cd};
      sv <= st;
      @(posedge clk);
      sel <= '1;
      sv <= ~st;
      @(posedge clk);
      vld <= 1'b0;
      for (int i = 0; i < 4 && loaded !== 1'b1; i++) @(negedge clk);
      chk("loaded", {15'h0000, loaded}, 16'h0001);
      repeat (12) @(posedge clk);
      repeat (6) begin
        r = lf(r);
        x = r;
        if (cd inside {5'h05, 5'h06, 5'h07}) x[0] = 1'b1;
        p = p ^ x[3];
        {rxf, txe, rd, wr, chg, cfgd, susp} <= x[6:0];
        go <= {6{x[6]}};
        goe <= {6{x[5]}};
        lvl <= {6{x[7]}};
        sof <= x[3];
        @(posedge clk);
        sof <= 1'b0;
        repeat (3) @(posedge clk);
        q.push_back(ex(cd, x));
      end
    end
    @(posedge clk);
    final_report();
  end
endmodule : capsel_tb_top
